// *** shared/vsl_defs.svh ***
// constants for the vertical sync, blanking and lookup port block
`ifndef VSL_DEFS_SVH
`define VSL_DEFS_SVH

`define VSL_OFS_VSYNC 8'h00
`define VSL_OFS_BLANK 8'h04
`define VSL_OFS_LUTCTL 8'h08
`define VSL_OFS_LUTWR 8'h0c
`define VSL_OFS_LUTRD 8'h10
`define VSL_OFS_CTRL 8'h14

`define VSL_RST16 16'h0000

`define VSL_LUT_EN_BIT 15
`define VSL_LUT_BUSY_BIT 14
`define VSL_LUT_TRIG_BIT 9
`define VSL_LUT_HOST_BIT 8
`define VSL_CTRL_VSOE_BIT 0
`define VSL_CTRL_DISPON_BIT 1

`define VSL_H_TOTAL 11'd400
`define VSL_H_ACTIVE 12'd320
`define VSL_V_TOTAL 11'd262
`define VSL_V_ACTIVE 12'd240

`endif

// *** shared/vsl_pkg.sv ***
// types shared by the lookup port block
package vsl_pkg;

  typedef enum logic [3:0] {
    LK_IDLE = 4'b0001,
    LK_WR = 4'b0010,
    LK_RDA = 4'b0100,
    LK_RDD = 4'b1000
  } vsl_lk_state_t;

endpackage

// *** verilog/vsl_lut_ram.sv ***
// colour lookup table storage, one port, registered read
`timescale 1ns/1ps

module vsl_lut_ram (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  logic [15:0] mem [0:255];
  logic [15:0] rdata_q;

  // storage carries no reset so it maps onto a plain ram macro
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= mem[addr];
    end
  end

  assign rdata = rdata_q;

endmodule

// *** verilog/vsl_top.sv ***
// vertical sync, blanking offsets and colour lookup host port
`timescale 1ns/1ps
`include "vsl_defs.svh"

module vsl_top (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [7:0] PIX_INDEX,
  output logic VSYNC_OUT,
  output logic DATA_EN,
  output logic [15:0] PIX_OUT,
  output logic PANEL_POWER_OUT
);

  // register bank
  logic [15:0] vsync_timing_q;
  logic [15:0] blank_ofs_q;
  logic lookup_enable_q;
  logic lookup_read_trigger_q;
  logic lookup_host_access_q;
  logic [7:0] lookup_index_q;
  logic [15:0] lookup_write_word_q;
  logic [15:0] lookup_read_word_q;
  logic vsync_output_enable_q;
  logic display_on_q;

  // bus
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic acc;
  logic wr;
  logic [7:0] word_adr;
  logic hit_vsync;
  logic hit_blank;
  logic hit_lutctl;
  logic hit_lutwr;
  logic hit_lutrd;
  logic hit_ctrl;

  // lookup access
  vsl_pkg::vsl_lk_state_t lk_state_q;
  vsl_pkg::vsl_lk_state_t lk_state_d;
  logic wr_pend_q;
  logic rd_pend_q;
  logic trig_prev_q;
  logic table_wr_req;
  logic table_rd_req;
  logic lookup_busy;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [15:0] ram_rdata;

  // timing
  logic [10:0] hcount_q;
  logic [10:0] vcount_q;
  logic line_end;
  logic [11:0] vs_begin;
  logic [11:0] vs_stop;
  logic [11:0] h_first;
  logic [11:0] v_first;
  logic vs_on;
  logic de_now;
  logic vs1_q;
  logic de1_q;
  logic [7:0] idx1_q;
  logic use_lut1_q;

  // panel power sequencing
  logic [15:0] pwr_cnt_q;
  logic pwr_out_q;
  logic dispon_wr;

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0] sel
  );
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  assign acc = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr = acc & WB_WE_I;
  assign word_adr = {WB_ADR_I[7:2], 2'b00};
  assign hit_vsync = word_adr == `VSL_OFS_VSYNC;
  assign hit_blank = word_adr == `VSL_OFS_BLANK;
  assign hit_lutctl = word_adr == `VSL_OFS_LUTCTL;
  assign hit_lutwr = word_adr == `VSL_OFS_LUTWR;
  assign hit_lutrd = word_adr == `VSL_OFS_LUTRD;
  assign hit_ctrl = word_adr == `VSL_OFS_CTRL;

  // one wait-free answer: ack one cycle after the strobe, then drop
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_vsync) begin
      rd_d[15:0] = vsync_timing_q;
    end else if (hit_blank) begin
      rd_d[15:0] = blank_ofs_q;
    end else if (hit_lutctl) begin
      rd_d[`VSL_LUT_EN_BIT] = lookup_enable_q;
      rd_d[`VSL_LUT_BUSY_BIT] = lookup_busy;
      rd_d[13:10] = 4'h0;
      rd_d[`VSL_LUT_TRIG_BIT] = lookup_read_trigger_q;
      rd_d[`VSL_LUT_HOST_BIT] = lookup_host_access_q;
      rd_d[7:0] = lookup_index_q;
    end else if (hit_lutwr) begin
      rd_d[15:0] = lookup_write_word_q;
    end else if (hit_lutrd) begin
      rd_d[15:0] = lookup_read_word_q;
    end else if (hit_ctrl) begin
      rd_d[`VSL_CTRL_VSOE_BIT] = vsync_output_enable_q;
      rd_d[`VSL_CTRL_DISPON_BIT] = display_on_q;
    end
  end

  // unmapped reads still get an ack with zero data
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dat_q <= 32'h0000_0000;
    end else if (acc) begin
      dat_q <= WB_WE_I ? 32'h0000_0000 : rd_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vsync_timing_q <= `VSL_RST16;
      blank_ofs_q <= `VSL_RST16;
    end else begin
      if (wr && hit_vsync) begin
        vsync_timing_q <= merge16(vsync_timing_q, WB_DAT_I, WB_SEL_I);
      end
      if (wr && hit_blank) begin
        blank_ofs_q <= merge16(blank_ofs_q, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // bit 14 and bits 13:10 hold no storage, so writes to them vanish
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lookup_enable_q <= 1'b0;
      lookup_read_trigger_q <= 1'b0;
      lookup_host_access_q <= 1'b0;
      lookup_index_q <= 8'h00;
    end else if (wr && hit_lutctl) begin
      if (WB_SEL_I[1]) begin
        lookup_enable_q <= WB_DAT_I[`VSL_LUT_EN_BIT];
        lookup_read_trigger_q <= WB_DAT_I[`VSL_LUT_TRIG_BIT];
        lookup_host_access_q <= WB_DAT_I[`VSL_LUT_HOST_BIT];
      end
      if (WB_SEL_I[0]) begin
        lookup_index_q <= WB_DAT_I[7:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lookup_write_word_q <= `VSL_RST16;
    end else if (wr && hit_lutwr) begin
      lookup_write_word_q <= merge16(lookup_write_word_q, WB_DAT_I,
                                     WB_SEL_I);
    end
  end

  assign dispon_wr = wr && hit_ctrl && WB_SEL_I[0];

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vsync_output_enable_q <= 1'b0;
      display_on_q <= 1'b0;
    end else if (dispon_wr) begin
      vsync_output_enable_q <= WB_DAT_I[`VSL_CTRL_VSOE_BIT];
      display_on_q <= WB_DAT_I[`VSL_CTRL_DISPON_BIT];
    end
  end

  // only a write touching the upper lane reaches the table
  assign table_wr_req = wr && hit_lutwr && WB_SEL_I[1]
                        && lookup_host_access_q;
  assign table_rd_req = lookup_read_trigger_q && !trig_prev_q
                        && lookup_host_access_q;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= lookup_read_trigger_q;
    end
  end

  // a request landing while the machine takes the previous one is kept
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      if (table_wr_req) begin
        wr_pend_q <= 1'b1;
      end else if (lk_state_q == vsl_pkg::LK_WR) begin
        wr_pend_q <= 1'b0;
      end
      if (table_rd_req) begin
        rd_pend_q <= 1'b1;
      end else if (lk_state_q == vsl_pkg::LK_RDA) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  always_comb begin
    case (lk_state_q)
      vsl_pkg::LK_IDLE: begin
        if (wr_pend_q) begin
          lk_state_d = vsl_pkg::LK_WR;
        end else if (rd_pend_q) begin
          lk_state_d = vsl_pkg::LK_RDA;
        end else begin
          lk_state_d = vsl_pkg::LK_IDLE;
        end
      end
      vsl_pkg::LK_WR: lk_state_d = vsl_pkg::LK_IDLE;
      vsl_pkg::LK_RDA: lk_state_d = vsl_pkg::LK_RDD;
      vsl_pkg::LK_RDD: lk_state_d = vsl_pkg::LK_IDLE;
      default: lk_state_d = vsl_pkg::LK_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lk_state_q <= vsl_pkg::LK_IDLE;
    end else begin
      lk_state_q <= lk_state_d;
    end
  end

  assign lookup_busy = lk_state_q != vsl_pkg::LK_IDLE;
  assign ram_we = lk_state_q == vsl_pkg::LK_WR;
  // host owns the address port while access is granted
  assign ram_addr = lookup_host_access_q ? lookup_index_q
                                         : PIX_INDEX;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lookup_read_word_q <= `VSL_RST16;
    end else if (lk_state_q == vsl_pkg::LK_RDD) begin
      lookup_read_word_q <= ram_rdata;
    end
  end

  vsl_lut_ram u_ram (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(lookup_write_word_q),
    .rdata(ram_rdata)
  );

  // raster counters: blanking of each line and frame begins at count 0
  assign line_end = hcount_q == (`VSL_H_TOTAL - 11'd1);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hcount_q <= 11'd0;
      vcount_q <= 11'd0;
    end else if (line_end) begin
      hcount_q <= 11'd0;
      if (vcount_q == (`VSL_V_TOTAL - 11'd1)) begin
        vcount_q <= 11'd0;
      end else begin
        vcount_q <= vcount_q + 11'd1;
      end
    end else begin
      hcount_q <= hcount_q + 11'd1;
    end
  end

  assign vs_begin = {4'h0, vsync_timing_q[7:0]};
  assign vs_stop = vs_begin + {4'h0, vsync_timing_q[15:8]};
  assign v_first = {4'h0, blank_ofs_q[15:8]};
  assign h_first = {4'h0, blank_ofs_q[7:0]};

  // a zero width gives no pulse at all; software must program one or more
  assign vs_on = ({1'b0, vcount_q} >= vs_begin)
                 && ({1'b0, vcount_q} < vs_stop);
  assign de_now = ({1'b0, vcount_q} >= v_first)
                  && ({1'b0, vcount_q} < v_first + `VSL_V_ACTIVE)
                  && ({1'b0, hcount_q} >= h_first)
                  && ({1'b0, hcount_q} < h_first + `VSL_H_ACTIVE);

  // stage one follows the ram address, stage two takes the ram output
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vs1_q <= 1'b0;
      de1_q <= 1'b0;
      idx1_q <= 8'h00;
      use_lut1_q <= 1'b0;
    end else begin
      vs1_q <= vs_on && vsync_output_enable_q;
      de1_q <= de_now;
      idx1_q <= PIX_INDEX;
      use_lut1_q <= lookup_enable_q && !lookup_host_access_q;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      VSYNC_OUT <= 1'b0;
      DATA_EN <= 1'b0;
      PIX_OUT <= 16'h0000;
    end else begin
      VSYNC_OUT <= vs1_q;
      DATA_EN <= de1_q;
      if (!de1_q) begin
        PIX_OUT <= 16'h0000;
      end else if (use_lut1_q) begin
        PIX_OUT <= ram_rdata;
      end else begin
        PIX_OUT <= {8'h00, idx1_q};
      end
    end
  end

  // power sequencing waits the last write data value in lines
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwr_cnt_q <= 16'h0000;
      pwr_out_q <= 1'b0;
    end else if (dispon_wr
                 && WB_DAT_I[`VSL_CTRL_DISPON_BIT] != display_on_q) begin
      pwr_cnt_q <= lookup_write_word_q;
    end else if (line_end && pwr_out_q != display_on_q) begin
      if (pwr_cnt_q == 16'h0000) begin
        pwr_out_q <= display_on_q;
      end else begin
        pwr_cnt_q <= pwr_cnt_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PANEL_POWER_OUT <= 1'b0;
    end else begin
      PANEL_POWER_OUT <= pwr_out_q;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

endmodule

// *** tb/vsl_checker.sv ***
// port assertions for the sync, blanking and lookup block
`timescale 1ns/1ps
module vsl_checker (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [7:0] PIX_INDEX,
  input wire logic VSYNC_OUT,
  input wire logic DATA_EN,
  input wire logic [15:0] PIX_OUT,
  input wire logic PANEL_POWER_OUT
);
  logic take, wr, vsoe_q, host_q, en_q, dirty_q;
  logic [9:0] de_cnt_q;
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr = take && WB_WE_I;
  // shadows load at the same taking edge as the block's own registers
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vsoe_q <= 1'b0;
      host_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      if (wr && WB_SEL_I[0] && WB_ADR_I[7:2] == 6'h05) begin
        vsoe_q <= WB_DAT_I[0];
      end
      if (wr && WB_SEL_I[1] && WB_ADR_I[7:2] == 6'h02) begin
        host_q <= WB_DAT_I[8];
        en_q <= WB_DAT_I[15];
      end
    end
  end
  // a run cut short by reprogramming the offsets is not judged
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      de_cnt_q <= 10'd0;
      dirty_q <= 1'b0;
    end else begin
      de_cnt_q <= DATA_EN ? de_cnt_q + 10'd1 : 10'd0;
      dirty_q <= (wr && WB_ADR_I[7:2] == 6'h01)
                 || (dirty_q && !$fell(DATA_EN));
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  ack_resp_a: assert property (take |=> WB_ACK_O)
    else $error("request not answered in one cycle");
  rd_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
    else $error("upper read data not zero");
  ctl_zero_a: assert property (
    WB_ACK_O && !WB_WE_I && WB_ADR_I[7:2] == 6'h02
    |-> WB_DAT_O[13:10] == 4'h0)
    else $error("lookup control spare bits not zero");
  pix_blank_a: assert property (!DATA_EN |-> PIX_OUT == 16'h0000)
    else $error("pixel driven outside active window");
  vs_off_a: assert property (!vsoe_q [*3] |-> !VSYNC_OUT)
    else $error("vsync moved while output disabled");
  pix_bypass_a: assert property (
    (host_q || !en_q) [*3] ##0 DATA_EN
    |-> PIX_OUT == {8'h00, $past(PIX_INDEX, 2)})
    else $error("pixel not bypassed around the table");
  de_len_a: assert property (
    $fell(DATA_EN) && !dirty_q |-> de_cnt_q == 10'd320)
    else $error("active run length wrong");
  cover property ($rose(VSYNC_OUT));
  cover property ($fell(DATA_EN) && !dirty_q);
  cover property (WB_ACK_O && !WB_WE_I && WB_DAT_O[14]);
  cover property ($rose(PANEL_POWER_OUT));
endmodule

bind vsl_top vsl_checker u_chk (.CORE_CLK, .ARST_N, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O,
  .PIX_INDEX, .VSYNC_OUT, .DATA_EN, .PIX_OUT, .PANEL_POWER_OUT);

// *** tb/vsl_panel_model.sv ***
// display panel model: times the sync and active window it receives
`timescale 1ns/1ps
module vsl_panel_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic vsync,
  input wire logic de,
  input wire logic [15:0] pix,
  output int vs_rises,
  output int vs_len,
  output int de_off,
  output int de_len,
  output int de_runs,
  output logic [15:0] pix_first
);
  int t, t_vs, t_de;
  logic vs_d, de_d, armed;
  // a panel drives nothing back, so only measurements leave this model
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t <= 0;
      vs_rises <= 0;
      de_runs <= 0;
      vs_d <= 1'b0;
      de_d <= 1'b0;
      armed <= 1'b0;
    end else begin
      t <= t + 1;
      vs_d <= vsync;
      de_d <= de;
      if (vsync && !vs_d) begin
        vs_rises <= vs_rises + 1;
        t_vs <= t;
        armed <= 1'b1;
      end
      if (!vsync && vs_d) vs_len <= t - t_vs;
      if (de && !de_d) begin
        de_runs <= de_runs + 1;
        t_de <= t;
        pix_first <= pix;
        armed <= 1'b0;
        if (armed) de_off <= t - t_vs;
      end
      if (!de && de_d) de_len <= t - t_de;
    end
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the sync, blanking and lookup block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic clk, arst_n, cyc, stb, we, ack, vs, de, pwr;
  logic [7:0] adr, pidx;
  logic [3:0] sel;
  logic [31:0] dat, dato;
  logic [15:0] pix, q, pix_first;
  logic [15:0] mode [3] = '{16'h8100, 16'h0000, 16'h8000};
  logic [15:0] pexp [3] = '{16'h0006, 16'h0007, 16'h1255};
  logic [7:0] pins [3] = '{8'h06, 8'h07, 8'h06};
  int bad_count, checked, tc, vs_rises, vs_len, de_off, de_len, de_runs;
  vsl_top dut (.CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack), .PIX_INDEX(pidx),
    .VSYNC_OUT(vs), .DATA_EN(de), .PIX_OUT(pix), .PANEL_POWER_OUT(pwr));
  vsl_panel_model panel (.clk(clk), .arst_n(arst_n), .vsync(vs), .de(de),
    .pix(pix), .vs_rises(vs_rises), .vs_len(vs_len), .de_off(de_off),
    .de_len(de_len), .de_runs(de_runs), .pix_first(pix_first));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) tc <= arst_n ? tc + 1 : 0;
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [3:0] s, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0000, d};
    // no wait limit here: only the watchdog ends a hung request
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dato[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic lut_rd(input logic [7:0] i, input logic [15:0] e);
    int k;
    logic b;
    k = 0;
    b = 1'b0;
    bus(1'b1, 8'h08, 4'h3, {8'h03, i});
    do begin
      bus(1'b0, 8'h08, 4'h3, 16'h0000);
      if (q[14] === 1'b1) b = 1'b1;
      k++;
    end while ((q[14] !== 1'b0 || k < 2) && k < 20);
    `CHK("lookup busy seen", 1'b1, b)
    `CHK("lookup ctl idle", {8'h03, i}, q)
    bus(1'b0, 8'h10, 4'h3, 16'h0000);
    `CHK("table read", e, q)
    bus(1'b1, 8'h08, 4'h3, {8'h01, i});
  endtask
  // waits past the fall of the next active run so its figures are final
  task automatic next_run;
    int r, k;
    r = de_runs;
    k = 0;
    while ((de_runs == r || de !== 1'b0) && k < 6000) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    if (k >= 6000) bad_count++;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    int k;
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    pidx = 8'h05;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b1, 8'h18, 4'h3, 16'hffff);
    for (int a = 0; a < 28; a += 4) begin
      bus(1'b0, a[7:0], 4'h3, 16'h0000);
      `CHK("reset value", 16'h0000, q)
    end
    $display("test reset values done");
    bus(1'b1, 8'h00, 4'h3, 16'h0201);
    bus(1'b1, 8'h04, 4'h3, 16'h080a);
    bus(1'b0, 8'h04, 4'h3, 16'h0000);
    `CHK("blanking reg", 16'h080a, q)
    bus(1'b1, 8'h08, 4'h3, 16'h3d05);
    bus(1'b0, 8'h08, 4'h3, 16'h0000);
    `CHK("lookup ctl", 16'h0105, q)
    bus(1'b1, 8'h0c, 4'h3, 16'hbeef);
    bus(1'b1, 8'h08, 4'h3, 16'h0107);
    bus(1'b1, 8'h0c, 4'h3, 16'haaaa);
    bus(1'b1, 8'h0c, 4'h1, 16'h0055);
    bus(1'b1, 8'h08, 4'h3, 16'h0106);
    bus(1'b1, 8'h0c, 4'h2, 16'h1234);
    bus(1'b0, 8'h0c, 4'h3, 16'h0000);
    `CHK("write data reg", 16'h1255, q)
    lut_rd(8'h05, 16'hbeef);
    lut_rd(8'h06, 16'h1255);
    lut_rd(8'h07, 16'haaaa);
    $display("test lookup port done");
    while (tc < 1300) @(posedge clk);
    `CHK("vsync while disabled", 0, vs_rises)
    bus(1'b1, 8'h00, 4'h3, 16'h0205);
    bus(1'b1, 8'h14, 4'h3, 16'h0001);
    next_run;
    `CHK("vsync width", 800, vs_len)
    `CHK("first pixel offset", 1210, de_off)
    `CHK("active run", 320, de_len)
    $display("test raster timing done");
    for (int i = 0; i < 3; i++) begin
      pidx <= pins[i];
      bus(1'b1, 8'h08, 4'h3, mode[i]);
      next_run;
      `CHK("pixel value", pexp[i], pix_first)
    end
    $display("test pixel path done");
    bus(1'b1, 8'h0c, 4'h3, 16'h0003);
    bus(1'b1, 8'h14, 4'h3, 16'h0003);
    // three lines of count must pass before power may follow
    repeat (1150) @(posedge clk);
    `CHK("panel power early", 1'b0, pwr)
    k = 0;
    while (pwr !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    `CHK("panel power on", 1'b1, pwr)
    $display("test panel power done");
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim;
  end
endmodule
